/* File: shared/nft_pkg.sv */
package nft_pkg;

  // ************************************************************
  // Register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ENERGY = 8'h04;
  localparam logic [7:0] OFS_HOLD   = 8'h08;
  localparam logic [7:0] OFS_CHOPP  = 8'h0C;
  localparam logic [7:0] OFS_CHOFF  = 8'h10;
  localparam logic [7:0] OFS_PAT0   = 8'h14;
  localparam logic [7:0] OFS_PAT1   = 8'h18;
  localparam logic [7:0] OFS_PAT2   = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Control register field positions
  localparam int CTRL_NEEDLE_LSB = 0;
  localparam int CTRL_DIR_BIT    = 2;
  localparam int CTRL_DMA_BIT    = 3;
  localparam int CTRL_TRST_BIT   = 4;
  localparam int CTRL_EN_BIT     = 5;

  // Needle count codes
  localparam logic [1:0] NEEDLES_9  = 2'h0;
  localparam logic [1:0] NEEDLES_18 = 2'h1;

  // ************************************************************
  // Timing: base clock recreated from the system clock
  // ************************************************************
  localparam int SYS_CLK_KHZ  = 250000;
  localparam int BASE_CLK_KHZ = 12288;
  localparam int PRESCALE     = 16;
  localparam int DISCH_TICKS  = 23;

  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] TIMER_RST = 32'h0000_0000;

  // Firing phases, Gray along the cycle
  typedef enum logic [1:0] {
    PH_IDLE     = 2'b00,
    PH_ENERGIZE = 2'b01,
    PH_HOLD     = 2'b11,
    PH_DISCHRG  = 2'b10
  } nft_phase_t;

  // Print head control settings
  typedef struct packed {
    logic       timerEnable;
    logic       dmaRequest;
    logic       printDir;
    logic [1:0] needleCount;
  } nft_ctrl_t;

endpackage : nft_pkg

/* File: rtl/nft_needle_firing_timer.sv */
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
// Overview of operation
// RQ1 - All needle timers advance on a tick made by dividing the 12.288 MHz base clock by 16.
// RQ2 - The control register holds needle count, direction, DMA request, timer reset and enable.
// RQ3 - A writable value sets the energize interval length in prescaled ticks.
// RQ4 - A writable value sets the hold interval length in prescaled ticks.
// RQ5 - A writable value sets the chopper period used during firing.
// RQ6 - A writable value sets the coil off-time inside each chopper period.
// RQ7 - Three consecutive registers hold a needle pattern of up to 24 bits.
// RQ8 - DMA requests load each needle pattern and ask for the bit map to be cleared.
// RQ9 - A firing cycle energizes, chops on and off, then discharges to the supply.
// RQ10 - Software programs low energy as 100, 100, 37.5 and 12.5 microseconds.
// RQ11 - Software programs normal energy as 115 and 85 microseconds, same chopper.
// RQ12 - Firing cycles start no faster than 2400 per second for text, 2100 for graphics; the code sets no rate limit.
// RQ13 - Timer reset clears all timers; timers count only when enabled; hold follows energize.
module nft_needle_firing_timer
  import nft_pkg::*;
#(
  parameter int TW = 12,
  parameter int NW = 24
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // DMA handshake
  output logic               dmaPatReq,
  output logic               dmaClrReq,
  input  wire logic          dmaClrAck,
  // Head drive
  output logic [NW-1:0]      coilDrive,
  output logic [NW-1:0]      coilClamp,
  output logic               headDir
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic            setupPh;
  logic            wrEn;
  logic            hitCtrl;
  logic            hitT1;
  logic            hitT2;
  logic            hitT3;
  logic            hitT4;
  logic            hitP0;
  logic            hitP1;
  logic            hitP2;
  logic            hitStat;
  logic            mapped;
  logic            accessPh;

  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign hitCtrl  = paddr == OFS_CTRL;
  assign hitT1    = paddr == OFS_ENERGY;
  assign hitT2    = paddr == OFS_HOLD;
  assign hitT3    = paddr == OFS_CHOPP;
  assign hitT4    = paddr == OFS_CHOFF;
  assign hitP0    = paddr == OFS_PAT0;
  assign hitP1    = paddr == OFS_PAT1;
  assign hitP2    = paddr == OFS_PAT2;
  assign hitStat  = paddr == OFS_STATUS;
  assign mapped   = hitCtrl | hitT1 | hitT2 | hitT3 | hitT4 | hitP0 | hitP1 | hitP2
                  | hitStat;
  assign wrEn     = accessPh && pwrite && mapped;
  // Zero-wait slave; errors only flag an unmapped access
  assign pready   = 1'b1;
  assign pslverr  = accessPh && !mapped;

  // ************************************************************
  // Registers
  // ************************************************************
  nft_ctrl_t       ctrl_reg;
  logic [TW-1:0]   t1_reg;
  logic [TW-1:0]   t2_reg;
  logic [TW-1:0]   t3_reg;
  logic [TW-1:0]   t4_reg;
  logic [23:0]     pat_reg;
  logic            patValid_reg;
  logic            timerReset;
  logic [31:0]     rdMux;
  logic [31:0]     prdata_reg;

  // Reset bit is a write-one pulse, it never reads back as set
  assign timerReset = wrEn && hitCtrl && pwdata[CTRL_TRST_BIT];  // see RQ13

  // Setting registers written by software
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reg <= nft_ctrl_t'(CTRL_RST[4:0]);
      t1_reg   <= TIMER_RST[TW-1:0];
      t2_reg   <= TIMER_RST[TW-1:0];
      t3_reg   <= TIMER_RST[TW-1:0];
      t4_reg   <= TIMER_RST[TW-1:0];
      pat_reg  <= 24'h00_0000;
    end
    else if (wrEn)
    begin
      if (hitCtrl)
        ctrl_reg <= nft_ctrl_t'({pwdata[CTRL_EN_BIT], pwdata[CTRL_DMA_BIT],
                                 pwdata[CTRL_DIR_BIT], pwdata[CTRL_NEEDLE_LSB +: 2]});  // see RQ2
      if (hitT1) t1_reg <= pwdata[TW-1:0];  // see RQ3
      if (hitT2) t2_reg <= pwdata[TW-1:0];  // see RQ4
      if (hitT3) t3_reg <= pwdata[TW-1:0];  // see RQ5
      if (hitT4) t4_reg <= pwdata[TW-1:0];  // see RQ6
      if (hitP0) pat_reg[7:0]   <= pwdata[7:0];  // see RQ7
      if (hitP1) pat_reg[15:8]  <= pwdata[7:0];  // see RQ7
      if (hitP2) pat_reg[23:16] <= pwdata[7:0];  // see RQ7
    end
  end

  // ************************************************************
  // Prescaler: fractional step rebuilds the base clock, then /16
  // ************************************************************
  logic [17:0]     acc_reg;
  logic [18:0]     accSum;
  logic            baseTick;
  logic [3:0]      pre_reg;
  logic            tick_reg;

  assign accSum   = {1'b0, acc_reg} + 19'(BASE_CLK_KHZ);
  assign baseTick = accSum >= 19'(SYS_CLK_KHZ);

  // Jitter of one system clock per base edge is the price of a 250 MHz source
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_reg  <= 18'h0_0000;
      pre_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      acc_reg  <= baseTick ? 18'(accSum - 19'(SYS_CLK_KHZ)) : accSum[17:0];  // see RQ1
      pre_reg  <= timerReset ? 4'h0 : (baseTick ? pre_reg + 4'h1 : pre_reg);  // see RQ1
      tick_reg <= baseTick && (pre_reg == 4'(PRESCALE - 1)) && !timerReset;  // see RQ1
    end
  end

  // ************************************************************
  // Firing sequencer
  // ************************************************************
  nft_phase_t      phase_reg;
  nft_phase_t      phase_next;
  logic [TW-1:0]   cnt_reg;
  logic [TW-1:0]   cnt_next;
  logic [TW-1:0]   chop_reg;
  logic [TW-1:0]   chop_next;
  logic [23:0]     act_reg;
  logic            step;
  logic            expire;
  logic            start;
  logic            chopWrap;
  logic            chopOff;
  logic [NW-1:0]   needleMask;

  // Counting needs the enable; a pending pattern launches a cycle
  assign step     = tick_reg && ctrl_reg.timerEnable;  // see RQ13
  assign expire   = cnt_reg <= TW'(1);
  // A timer reset in the same cycle must not swallow the pending pattern
  assign start    = step && !timerReset && (phase_reg == PH_IDLE) && patValid_reg;
  assign chopWrap = chop_reg + TW'(1) >= t3_reg;
  // Off window sits at the tail of each chopper period
  assign chopOff  = ({1'b0, chop_reg} + {1'b0, t4_reg}) >= {1'b0, t3_reg};  // see RQ6

  // Phase and counter next values
  always_comb
  begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    chop_next  = chop_reg;
    if (timerReset)
    begin
      phase_next = PH_IDLE;  // see RQ13
      cnt_next   = '0;
      chop_next  = '0;
    end
    else if (step)
    begin
      unique case (phase_reg)
        PH_IDLE:
          if (start)
          begin
            phase_next = PH_ENERGIZE;  // see RQ9
            cnt_next   = t1_reg;  // see RQ3
          end
        PH_ENERGIZE:
          if (expire)
          begin
            phase_next = PH_HOLD;  // see RQ13
            cnt_next   = t2_reg;  // see RQ4
            chop_next  = '0;
          end
          else
            cnt_next = cnt_reg - TW'(1);
        PH_HOLD:
        begin
          chop_next = chopWrap ? '0 : chop_reg + TW'(1);  // see RQ5
          if (expire)
          begin
            phase_next = PH_DISCHRG;  // see RQ9
            cnt_next   = TW'(DISCH_TICKS);
          end
          else
            cnt_next = cnt_reg - TW'(1);
        end
        PH_DISCHRG:
          if (expire)
            phase_next = PH_IDLE;
          else
            cnt_next = cnt_reg - TW'(1);
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= '0;
      chop_reg  <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      chop_reg  <= chop_next;
    end
  end

  // ************************************************************
  // Pattern hand-off and DMA requests
  // ************************************************************
  // Top byte write completes a pattern; the set beats a same-cycle start
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      patValid_reg <= 1'b0;
      act_reg      <= 24'h00_0000;
      dmaClrReq    <= 1'b0;
    end
    else
    begin
      patValid_reg <= (wrEn && hitP2) || (patValid_reg && !start);  // see RQ7
      if (start)
        act_reg <= pat_reg;
      dmaClrReq <= start || (dmaClrReq && !dmaClrAck);  // see RQ8
    end
  end

  // Pattern request stays up while the head waits for a new column
  assign dmaPatReq = ctrl_reg.dmaRequest && !patValid_reg;  // see RQ8

  // ************************************************************
  // Coil drive outputs
  // ************************************************************
  logic            driveOn;
  logic            clampOn;
  logic [23:0]     firePat;

  // The active copy loads on the start edge itself, so bypass it there
  assign firePat = start ? pat_reg : act_reg;  // see RQ7

  assign needleMask = (ctrl_reg.needleCount == NEEDLES_9)  ? NW'(24'h00_01FF) :
                      (ctrl_reg.needleCount == NEEDLES_18) ? NW'(24'h03_FFFF) :
                                                             NW'(24'hFF_FFFF);
  // Drive chops in hold; clamp keeps recirculation until discharge
  assign driveOn = (phase_next == PH_ENERGIZE)
                || (phase_next == PH_HOLD && !((phase_reg == PH_HOLD) && chopOff));  // see RQ9
  assign clampOn = (phase_next == PH_ENERGIZE) || (phase_next == PH_HOLD);  // see RQ9

  // Registered so the coil transistors never see decode glitches
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      coilDrive <= '0;
      coilClamp <= '0;
      headDir   <= 1'b0;
    end
    else
    begin
      coilDrive <= driveOn ? (NW'(firePat) & needleMask) : '0;
      coilClamp <= clampOn ? (NW'(firePat) & needleMask) : '0;
      headDir   <= ctrl_reg.printDir;
    end
  end

  // ************************************************************
  // Read data, captured in the setup cycle
  // ************************************************************
  assign rdMux = hitCtrl ? {26'h0, ctrl_reg.timerEnable, 1'b0, ctrl_reg.dmaRequest,
                            ctrl_reg.printDir, ctrl_reg.needleCount} :
                 hitT1   ? 32'(t1_reg) :
                 hitT2   ? 32'(t2_reg) :
                 hitT3   ? 32'(t3_reg) :
                 hitT4   ? 32'(t4_reg) :
                 hitP0   ? {24'h0, pat_reg[7:0]} :
                 hitP1   ? {24'h0, pat_reg[15:8]} :
                 hitP2   ? {24'h0, pat_reg[23:16]} :
                 hitStat ? {27'h0, |coilDrive, dmaClrReq, patValid_reg, phase_reg} :
                           32'h0000_0000;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prdata_reg <= 32'h0000_0000;
    else if (setupPh)
      prdata_reg <= rdMux;
  end

  assign prdata = prdata_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_tick_spacing: assert property (tick_reg |=> !tick_reg [*8])  // see RQ1
    else $error("Prescaled tick too frequent");
  a_reset_idles: assert property (timerReset |=> phase_reg == PH_IDLE && cnt_reg == '0)  // see RQ13
    else $error("Timer reset did not clear sequencer");
  a_disabled_frozen: assert property (!ctrl_reg.timerEnable && !timerReset
      |=> $stable(phase_reg) && $stable(cnt_reg))  // see RQ13
    else $error("Timers moved while disabled");
  a_energize_to_hold: assert property (step && !timerReset && phase_reg == PH_ENERGIZE
      && expire |=> phase_reg == PH_HOLD && cnt_reg == t2_reg)  // see RQ4
    else $error("Hold did not follow energize");
  a_start_loads_t1: assert property (start && !timerReset
      |=> phase_reg == PH_ENERGIZE && cnt_reg == t1_reg)  // see RQ3
    else $error("Energize interval not loaded");
  a_discharge_off: assert property (phase_reg == PH_DISCHRG |-> coilDrive == '0
      && coilClamp == '0)  // see RQ9
    else $error("Coil driven in discharge");
  a_chop_off: assert property (phase_reg == PH_HOLD && $past(phase_reg) == PH_HOLD
      && $past(chopOff) && $past(phase_next) == PH_HOLD |-> coilDrive == '0)  // see RQ6
    else $error("Coil on in chopper off window");
  a_dma_pattern: assert property (wrEn && hitP2 |=> patValid_reg && !dmaPatReq)  // see RQ8
    else $error("Pattern request not withdrawn");
  a_clear_request: assert property (start |=> dmaClrReq)  // see RQ8
    else $error("Bit map clear not requested");
  a_apb_unmapped: assert property (accessPh && !mapped |-> pslverr && pready)
    else $error("Unmapped access not flagged");

  c_full_cycle: cover property (phase_reg == PH_HOLD ##[1:300] phase_reg == PH_DISCHRG);
  c_chop_window: cover property (phase_reg == PH_HOLD && chopOff);
  c_clear_ack: cover property (dmaClrReq && dmaClrAck);
  c_reset_midfire: cover property (phase_reg == PH_ENERGIZE && timerReset);

endmodule : nft_needle_firing_timer

/* File: verif/nft_dma_model.sv */
`timescale 1ns/100ps
// ************************************************************
// DMA side: answers each bit map clear request
// ************************************************************
module nft_dma_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Answer speed, high makes the channel slow
  input  wire logic slow,
  // Clear handshake
  input  wire logic dmaClrReq,
  output logic      dmaClrAck
);
  int waitCnt;

  // One-cycle acknowledge after a prompt or a slow delay
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dmaClrAck <= 1'b0;
      waitCnt   <= 0;
    end
    else if (dmaClrReq && !dmaClrAck && waitCnt >= (slow ? 40 : 3))
    begin
      dmaClrAck <= 1'b1;
      waitCnt   <= 0;
    end
    else
    begin
      dmaClrAck <= 1'b0;
      waitCnt   <= (dmaClrReq && !dmaClrAck) ? waitCnt + 1 : 0;
    end
  end
endmodule : nft_dma_model

/* File: verif/tb_needle_firing_timer.sv */
`timescale 1ns/100ps
module tb_needle_firing_timer;
  import nft_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } nft_row_t;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic        dmaPatReq, dmaClrReq, dmaClrAck, headDir, slowAck;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, s1;
  logic [23:0] coilDrive, coilClamp, c1;
  int          err_count, cmp_count, n, on, off;
  localparam logic [23:0] PAT = 24'hA5_5AC3;
  nft_row_t    rows [8];

  nft_needle_firing_timer nft_needle_firing_timer_i (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dmaPatReq(dmaPatReq),
    .dmaClrReq(dmaClrReq), .dmaClrAck(dmaClrAck), .coilDrive(coilDrive),
    .coilClamp(coilClamp), .headDir(headDir));
  nft_dma_model nft_dma_model_i (.clk(clk), .nrst(nrst), .slow(slowAck),
    .dmaClrReq(dmaClrReq), .dmaClrAck(dmaClrAck));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic bail(input string nm);
    $display("wrong value %s expected done seen timeout", nm);
    err_count++;
    tally_and_finish();
  endtask : bail

  // Held from setup to the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    begin
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
        bail("pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  // Waits for the clamp level, counting drive on and off cycles
  task automatic waitClamp(input logic lvl);
    n = 0;
    on = 0;
    off = 0;
    while ((|coilClamp) !== lvl)
    begin
      @(posedge clk);
      n++;
      if (coilDrive === 24'h0) off++;
      else on++;
      if (n > 20000) bail("clamp");
    end
  endtask : waitClamp

  task automatic arm(input logic [1:0] nc, input logic dir);
    for (int i = 0; i < 3; i++)
      apb(1'b1, OFS_PAT0 + 8'(4 * i), {24'h0, PAT[8 * i +: 8]});
    apb(1'b1, OFS_CTRL, {26'h0, 1'b1, 2'b00, dir, nc});
    waitClamp(1'b1);
  endtask : arm

  task automatic status(input string nm, input logic [1:0] ph);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(nm, {30'h0, ph}, {30'h0, rd[1:0]});
  endtask : status

  // Full firing cycle: 16 energize plus hold ticks, 23 discharge ticks
  task automatic fire(input logic [1:0] nc, input logic dir, input logic [23:0] exp);
    arm(nc, dir);
    chk("drive", {8'h0, exp}, {8'h0, coilDrive});
    chk("dir", {31'h0, dir}, {31'h0, headDir});
    chk("clrReq", 32'h1, {31'h0, dmaClrReq});
    waitClamp(1'b0);
    chk("span", 32'h1, 32'(n >= 5207 && n <= 5210));
    chk("chop", 32'h1, 32'(off >= 648 && off <= 656));
    chk("clrDone", 32'h0, {31'h0, dmaClrReq});
    status("dischg", 2'h2);
    chk("dischgDrv", 32'h0, {8'h0, coilDrive});
    repeat (7290) @(posedge clk);
    status("dischgLate", 2'h2);
    repeat (300) @(posedge clk);
    // Next start only once idle, which keeps the firing rate in check
    status("idle", 2'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask : fire

  // ************************************************************
  // Clock and main sequence
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    {nrst, psel, penable, pwrite, slowAck} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    rows = '{'{OFS_ENERGY, 32'hFFFF_FABC, 32'h0000_0ABC, 1'b0},
             '{OFS_HOLD, 32'h0000_0123, 32'h0000_0123, 1'b0},
             '{OFS_CHOPP, 32'h0000_0FFF, 32'h0000_0FFF, 1'b0},
             '{OFS_CHOFF, 32'h0000_0001, 32'h0000_0001, 1'b0},
             '{OFS_CTRL, 32'h0000_001E, 32'h0000_000E, 1'b0},
             '{OFS_STATUS, 32'h0000_001F, 32'h0000_0000, 1'b0},
             '{8'h24, 32'h0000_00FF, 32'h0000_0000, 1'b1},
             '{8'hFC, 32'h0000_00FF, 32'h0000_0000, 1'b1}};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("rstOut", 32'h10, {27'h0, pready, pslverr, headDir, dmaPatReq, dmaClrReq});
    chk("rstCoil", 32'h0, {8'h0, coilClamp | coilDrive});
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("rstVal", 32'h0, rd);
    end
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk("wrErr", {31'h0, rows[i].e}, {31'h0, er});
      apb(1'b0, rows[i].a, 32'h0);
      chk("rdVal", rows[i].x, rd);
      chk("rdErr", {31'h0, rows[i].e}, {31'h0, er});
    end
    chk("patReq", 32'h1, {31'h0, dmaPatReq});
    for (int i = 0; i < 3; i++)
      apb(1'b1, OFS_PAT0 + 8'(4 * i), {24'h0, PAT[8 * i +: 8]});
    chk("patDone", 32'h0, {31'h0, dmaPatReq});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("patValid", 32'h1, {31'h0, rd[2]});
    apb(1'b1, OFS_CTRL, 32'h0);
    // Low energy with each 12.5 us scaled down to one tick so a firing fits the run
    apb(1'b1, OFS_ENERGY, 32'h8);
    apb(1'b1, OFS_HOLD, 32'h8);
    apb(1'b1, OFS_CHOPP, 32'h3);
    apb(1'b1, OFS_CHOFF, 32'h1);
    fire(NEEDLES_18 + 2'h1, 1'b0, PAT);
    slowAck <= 1'b1;
    // Normal energy: longer energize, same total and same chopper
    apb(1'b1, OFS_ENERGY, 32'h9);
    apb(1'b1, OFS_HOLD, 32'h7);
    fire(NEEDLES_9, 1'b1, PAT & 24'h00_01FF);
    // Enable low must freeze the cycle mid-hold; timer reset ends it
    arm(NEEDLES_18, 1'b0);
    repeat (3500) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b0, OFS_STATUS, 32'h0);
    s1 = rd;
    c1 = coilClamp;
    repeat (2000) @(posedge clk);
    chk("holdPh", 32'h3, {30'h0, s1[1:0]});
    chk("clamp18", {8'h0, PAT & 24'h03_FFFF}, {8'h0, c1});
    status("frozen", s1[1:0]);
    chk("frozenClamp", {8'h0, c1}, {8'h0, coilClamp});
    apb(1'b1, OFS_CTRL, 32'h0000_0015);
    status("trst", 2'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("trstBit", 32'h5, rd);
    chk("headDir", 32'h1, {31'h0, headDir});
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("midRst", 32'h0, {8'h0, coilClamp} | {31'h0, dmaClrReq} | {31'h0, headDir});
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("midRstCtrl", 32'h0, rd);
    tally_and_finish();
  end
endmodule : tb_needle_firing_timer
